// [core_page_decoder_emulate_mux.v]
/*
 * Glue between the processor core and the network core: relocatable page
 * decode with a page base register, emulate-mode pin turnaround, network
 * interrupt routing and the two derived clock enables.
 * Assumes the processor core and network core run on i_clk_sys; all pin
 * inputs are asynchronous. The network core answers reads combinationally
 * in the cycle its read pulse is high.
 */
`timescale 1ns/1ns
`include "core_page_defines.vh"

module core_page_decoder_emulate_mux #(
   parameter DIV_W = 8
) (
   input  wire       i_clk_sys,
   input  wire       i_rst,
   // external pins
   input  wire       i_external_access_select_n,
   input  wire [7:0] i_p0_in,
   output reg  [7:0] o_p0_out,
   output reg  [7:0] o_p0_oe,
   output reg  [7:0] o_p1_out,
   output reg  [7:0] o_p1_oe,
   input  wire [7:0] i_p2_in,
   output reg  [7:0] o_p2_out,
   output reg  [7:0] o_p2_oe,
   input  wire [7:0] i_p3_in,
   output reg  [7:0] o_p3_out,
   output reg  [7:0] o_p3_oe,
   input  wire       i_ale_in,
   output reg        o_ale_out,
   output reg        o_ale_oe,
   output reg        o_program_fetch_strobe_n_out,
   output reg        o_program_fetch_strobe_n_oe,
   // processor core side
   input  wire [7:0] i_cpu_p0_out,
   input  wire [7:0] i_cpu_p0_oe,
   input  wire [7:0] i_cpu_p1_out,
   input  wire [7:0] i_cpu_p1_oe,
   input  wire [7:0] i_cpu_p2_out,
   input  wire [7:0] i_cpu_p3_out,
   input  wire [7:0] i_cpu_p3_oe,
   input  wire       i_cpu_ale,
   input  wire       i_cpu_program_fetch_strobe_n,
   output reg        o_cpu_hold,
   output reg  [7:0] o_cpu_rdata,
   output reg        o_cpu_rdata_valid,
   output reg        o_cpu_ext_irq_a,
   output reg        o_cpu_ext_irq_b,
   output reg        o_cpu_clk_en,
   // network core side
   output reg        o_core_rd,
   output reg        o_core_wr,
   output reg  [7:0] o_core_addr,
   output reg  [7:0] o_core_wdata,
   input  wire [7:0] i_core_rdata,
   input  wire       i_net_irq,
   output reg        o_net_clk_en,
   // interrupt routing straps
   input  wire [1:0] i_irq_route,
   input  wire [2:0] i_irq_port_pin
);

   // ---------------------------------------------------------------
   // decode function
   // ---------------------------------------------------------------
   function [1:0] decode_hit;
      input [15:0] addr;
      input [7:0]  base;
      begin
         if (addr == `PAGE_BASE_ADDR) begin
            decode_hit = `HIT_PAGE_REG;
         end else if (addr[15:8] == base) begin
            decode_hit = `HIT_CORE;
         end else begin
            decode_hit = `HIT_NONE;
         end
      end
   endfunction

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   reg  [7:0] p0_s1;
   reg  [7:0] p0_s2;
   reg  [7:0] p2_s1;
   reg  [7:0] p2_s2;
   reg  [7:0] p3_s1;
   reg  [7:0] p3_s2;
   reg        ale_s1;
   reg        ale_s2;
   reg        ea_s1;
   reg        ea_s2;
   reg        emulate_flag;

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         p0_s1        <= 8'h00;
         p0_s2        <= 8'h00;
         p2_s1        <= 8'h00;
         p2_s2        <= 8'h00;
         p3_s1        <= 8'hff;
         p3_s2        <= 8'hff;
         ale_s1       <= 1'b0;
         ale_s2       <= 1'b0;
         ea_s1        <= 1'b0;
         ea_s2        <= 1'b0;
         emulate_flag <= 1'b0;
      end else begin
         p0_s1        <= i_p0_in;
         p0_s2        <= p0_s1;
         p2_s1        <= i_p2_in;
         p2_s2        <= p2_s1;
         p3_s1        <= i_p3_in;
         p3_s2        <= p3_s1;
         ale_s1       <= i_ale_in;
         ale_s2       <= ale_s1;
         ea_s1        <= i_external_access_select_n;
         ea_s2        <= ea_s1;
         emulate_flag <= ea_s2;
      end
   end

   // ---------------------------------------------------------------
   // bus source select
   // ---------------------------------------------------------------
   // the emulator's cycle is seen two clocks late through the
   // synchronisers; the strobes are long enough at 25 MHz to absorb that
   wire [7:0] src_p0   = emulate_flag ? p0_s2 : i_cpu_p0_out;
   wire [7:0] src_hi   = emulate_flag ? p2_s2 : i_cpu_p2_out;
   wire       src_ale  = emulate_flag ? ale_s2 : i_cpu_ale;
   wire       src_rd_n = emulate_flag ? p3_s2[`P3_RD] : i_cpu_p3_out[`P3_RD];
   wire       src_wr_n = emulate_flag ? p3_s2[`P3_WR] : i_cpu_p3_out[`P3_WR];

   // ---------------------------------------------------------------
   // bus cycle decode and page base register
   // ---------------------------------------------------------------
   reg  [7:0] addr_lo;
   reg        ale_d;
   reg        rd_n_d;
   reg        wr_n_d;
   reg  [1:0] cyc_hit;
   reg  [7:0] page_base;
   reg  [7:0] wdata;
   reg        read_drive;

   wire [1:0] hit_now   = decode_hit({src_hi, addr_lo}, page_base);
   wire       rd_fall   = rd_n_d & ~src_rd_n;
   wire       rd_rise   = ~rd_n_d & src_rd_n;
   wire       wr_fall   = wr_n_d & ~src_wr_n;
   wire       wr_rise   = ~wr_n_d & src_wr_n;

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         addr_lo           <= 8'h00;
         ale_d             <= 1'b0;
         rd_n_d            <= 1'b1;
         wr_n_d            <= 1'b1;
         cyc_hit           <= `HIT_NONE;
         page_base         <= `PAGE_BASE_RESET;
         wdata             <= 8'h00;
         read_drive        <= 1'b0;
         o_core_rd         <= 1'b0;
         o_core_wr         <= 1'b0;
         o_core_addr       <= 8'h00;
         o_core_wdata      <= 8'h00;
         o_cpu_rdata       <= 8'h00;
         o_cpu_rdata_valid <= 1'b0;
      end else begin
         ale_d     <= src_ale;
         rd_n_d    <= src_rd_n;
         wr_n_d    <= src_wr_n;
         o_core_rd <= 1'b0;
         o_core_wr <= 1'b0;
         if (ale_d && !src_ale) begin
            addr_lo <= src_p0;
         end
         if (!src_wr_n) begin
            wdata <= src_p0;
         end
         if (rd_fall || wr_fall) begin
            cyc_hit <= hit_now;
         end
         if (rd_fall && hit_now == `HIT_CORE) begin
            o_core_rd   <= 1'b1;
            o_core_addr <= addr_lo;
         end
         if (rd_fall && hit_now == `HIT_PAGE_REG) begin
            o_cpu_rdata       <= page_base;
            o_cpu_rdata_valid <= 1'b1;
            read_drive        <= 1'b1;
         end
         if (o_core_rd) begin
            o_cpu_rdata       <= i_core_rdata;
            o_cpu_rdata_valid <= 1'b1;
            read_drive        <= 1'b1;
         end
         if (rd_rise) begin
            o_cpu_rdata_valid <= 1'b0;
            read_drive        <= 1'b0;
         end
         // writes commit at the strobe's end, when the data is surely settled
         if (wr_rise && cyc_hit == `HIT_PAGE_REG) begin
            page_base <= wdata;
         end
         if (wr_rise && cyc_hit == `HIT_CORE) begin
            o_core_wr    <= 1'b1;
            o_core_addr  <= addr_lo;
            o_core_wdata <= wdata;
         end
      end
   end

   // ---------------------------------------------------------------
   // interrupt routing
   // ---------------------------------------------------------------
   wire       irq_to_a    = (i_irq_route == `ROUTE_INT_A) & i_net_irq;
   wire       irq_to_b    = (i_irq_route == `ROUTE_INT_B) & i_net_irq;
   wire       port_routed = (i_irq_route == `ROUTE_PORT);
   wire [7:0] port_mask   = port_routed ? (8'h01 << i_irq_port_pin) : 8'h00;

   // ---------------------------------------------------------------
   // pin direction and data mux
   // ---------------------------------------------------------------
   reg  [7:0] next_p0_out;
   reg  [7:0] next_p0_oe;
   reg  [7:0] next_p1_out;
   reg  [7:0] next_p1_oe;
   reg  [7:0] next_p3_out;
   reg  [7:0] next_p3_oe;

   always @* begin
      // a core or page register read is driven onto port 0 too
      next_p0_out = read_drive ? o_cpu_rdata : i_cpu_p0_out;
      next_p0_oe  = read_drive ? 8'hff : 8'h00;
      if (!emulate_flag) begin
         next_p0_oe = next_p0_oe | i_cpu_p0_oe;
      end
      // active-low interrupt level on the routed port 1 pin
      next_p1_out = (i_cpu_p1_out & ~port_mask) | ({8{~i_net_irq}} & port_mask);
      next_p1_oe  = emulate_flag ? port_mask : (i_cpu_p1_oe | port_mask);
      next_p3_out = i_cpu_p3_out;
      next_p3_oe  = i_cpu_p3_oe;
      next_p3_oe[`P3_INT_A] = 1'b0;
      next_p3_oe[`P3_INT_B] = 1'b0;
      if (emulate_flag) begin
         next_p3_oe              = 8'h00;
         next_p3_oe[`P3_INT_A]   = 1'b1;
         next_p3_oe[`P3_INT_B]   = 1'b1;
         next_p3_out[`P3_INT_A]  = ~irq_to_a;
         next_p3_out[`P3_INT_B]  = ~irq_to_b;
      end
   end

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_p0_out                     <= 8'h00;
         o_p0_oe                      <= 8'h00;
         o_p1_out                     <= 8'h00;
         o_p1_oe                      <= 8'h00;
         o_p2_out                     <= 8'h00;
         o_p2_oe                      <= 8'h00;
         o_p3_out                     <= 8'hff;
         o_p3_oe                      <= 8'h00;
         o_ale_out                    <= 1'b0;
         o_ale_oe                     <= 1'b0;
         o_program_fetch_strobe_n_out <= 1'b1;
         o_program_fetch_strobe_n_oe  <= 1'b0;
         o_cpu_hold                   <= 1'b0;
         o_cpu_ext_irq_a              <= 1'b0;
         o_cpu_ext_irq_b              <= 1'b0;
      end else begin
         o_p0_out                     <= next_p0_out;
         o_p0_oe                      <= next_p0_oe;
         o_p1_out                     <= next_p1_out;
         o_p1_oe                      <= next_p1_oe;
         o_p2_out                     <= i_cpu_p2_out;
         o_p2_oe                      <= {8{~emulate_flag}};
         o_p3_out                     <= next_p3_out;
         o_p3_oe                      <= next_p3_oe;
         o_ale_out                    <= i_cpu_ale;
         o_ale_oe                     <= ~emulate_flag;
         o_program_fetch_strobe_n_out <= i_cpu_program_fetch_strobe_n;
         o_program_fetch_strobe_n_oe  <= ~emulate_flag;
         o_cpu_hold                   <= emulate_flag;
         // in emulate mode the interrupt pins are our own outputs, so the
         // pin level is not folded back in
         o_cpu_ext_irq_a <= irq_to_a | (~emulate_flag & ~p3_s2[`P3_INT_A]);
         o_cpu_ext_irq_b <= irq_to_b | (~emulate_flag & ~p3_s2[`P3_INT_B]);
      end
   end

   // ---------------------------------------------------------------
   // derived clock enables
   // ---------------------------------------------------------------
   // rates are ratios of the oscillator, applied to i_clk_sys
   wire net_en;
   wire cpu_en;

   rate_enable_gen #(
      .ACC_W    (DIV_W),
      .RATE_NUM (`NET_CLK_MHZ),
      .RATE_DEN (`OSC_MHZ)
   ) u_net_en (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .o_en      (net_en)
   );

   rate_enable_gen #(
      .ACC_W    (DIV_W),
      .RATE_NUM (`CPU_CLK_MHZ),
      .RATE_DEN (`OSC_MHZ)
   ) u_cpu_en (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .o_en      (cpu_en)
   );

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_net_clk_en <= 1'b0;
         o_cpu_clk_en <= 1'b0;
      end else begin
         o_net_clk_en <= net_en;
         o_cpu_clk_en <= cpu_en;
      end
   end

endmodule // core_page_decoder_emulate_mux

// [core_page_decoder_emulate_mux_bench.sv]
/*
 * Self-checking bench: bus cycles in normal and emulate mode, page moves,
 * interrupt routing and clock enables.
 * Assumes the design, its defines header, the checker and the core model.
 */
`timescale 1ns/1ns
`include "core_page_defines.vh"

module core_page_decoder_emulate_mux_bench;
   reg        i_clk_sys = 1'b0;
   reg        i_rst     = 1'b1;
   reg        ea_n      = 1'b0;
   reg        ale       = 1'b0;
   reg        net_irq   = 1'b0;
   reg        emulate_flag_mode = 1'b0;
   reg        ok;
   reg        psen_n    = 1'b1;
   reg  [2:0] irq_pin   = 3'h5;
   reg  [1:0] rw_n      = 2'b11;
   reg  [1:0] pin_irq_n = 2'b11;
   reg  [1:0] route     = 2'h0;
   reg  [7:0] lo        = 8'h00;
   reg  [7:0] hi        = 8'h00;
   reg  [7:0] rd_count  = 8'h00;
   reg  [7:0] d;
   reg  [7:0] n;
   reg  [7:0] bases [0:2];
   integer    bad_count = 0;
   integer    total_checks = 0;
   integer    i;
   integer    net_n;
   integer    cpu_n;
   wire [7:0] p0_out, p0_oe, p1_out, p2_out, p2_oe, p3_out, p3_oe, p1_oe, cpu_rdata;
   wire [7:0] core_addr, core_wdata, core_rdata;
   wire       hold, valid, irq_a, irq_b, core_rd, core_wr, net_en, cpu_en, psen_out;
   // irq pins resolve between the design's drive and the board level
   wire [1:0] irq_pins = (p3_oe[3:2] & p3_out[3:2]) | (~p3_oe[3:2] & pin_irq_n);
   wire [7:0] p3_pins  = {rw_n, 2'b11, irq_pins, 2'b11};
   wire [7:0] p0_pins  = (p0_oe == 8'hff) ? p0_out : lo;

   always #20 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) if (core_rd === 1'b1) rd_count <= rd_count + 8'h01;

   core_page_decoder_emulate_mux #(.DIV_W(8)) u_dut (
      .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_external_access_select_n(ea_n),
      .i_p0_in(p0_pins), .o_p0_out(p0_out), .o_p0_oe(p0_oe), .o_p1_out(p1_out),
      .o_p1_oe(p1_oe), .i_p2_in(hi), .o_p2_out(p2_out), .o_p2_oe(p2_oe), .i_p3_in(p3_pins),
      .o_p3_out(p3_out), .o_p3_oe(p3_oe), .i_ale_in(ale), .o_ale_out(), .o_ale_oe(),
      .o_program_fetch_strobe_n_out(psen_out), .o_program_fetch_strobe_n_oe(),
      .i_cpu_p0_out(lo), .i_cpu_p0_oe(8'h00), .i_cpu_p1_out(lo), .i_cpu_p1_oe(8'hff),
      .i_cpu_p2_out(hi), .i_cpu_p3_out({rw_n, 6'h3f}), .i_cpu_p3_oe(8'hff), .i_cpu_ale(ale),
      .i_cpu_program_fetch_strobe_n(psen_n), .o_cpu_hold(hold), .o_cpu_rdata(cpu_rdata),
      .o_cpu_rdata_valid(valid), .o_cpu_ext_irq_a(irq_a), .o_cpu_ext_irq_b(irq_b),
      .o_cpu_clk_en(cpu_en), .o_core_rd(core_rd), .o_core_wr(core_wr), .o_core_addr(core_addr),
      .o_core_wdata(core_wdata), .i_core_rdata(core_rdata), .i_net_irq(net_irq),
      .o_net_clk_en(net_en), .i_irq_route(route), .i_irq_port_pin(irq_pin));

   net_core_model u_core (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rd(core_rd),
      .i_wr(core_wr), .i_addr(core_addr), .i_wdata(core_wdata), .o_rdata(core_rdata));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task check8(input [7:0] got, input [7:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task check1(input got, input exp);
      check8({7'h00, got}, {7'h00, exp});
   endtask

   task cyc(input [7:0] a_lo, input [7:0] a_hi, input a_ale, input [1:0] a_rw);
      @(posedge i_clk_sys);
      lo   <= a_lo;
      hi   <= a_hi;
      ale  <= a_ale;
      rw_n <= a_rw;
   endtask

   task bus_write(input [15:0] addr, input [7:0] data);
      cyc(addr[7:0], addr[15:8], 1'b1, 2'b11);
      cyc(addr[7:0], addr[15:8], 1'b0, 2'b11);
      repeat (4) cyc(data, addr[15:8], 1'b0, 2'b10);
      cyc(data, addr[15:8], 1'b0, 2'b11);
      repeat (4) @(posedge i_clk_sys);
   endtask

   // strobe is held until the answer shows, or eight cycles pass
   task bus_read(input [15:0] addr, output [7:0] data, output hit);
      integer w;
      cyc(addr[7:0], addr[15:8], 1'b1, 2'b11);
      cyc(addr[7:0], addr[15:8], 1'b0, 2'b11);
      cyc(addr[7:0], addr[15:8], 1'b0, 2'b01);
      hit = 1'b0;
      for (w = 0; w < 8 && !hit; w = w + 1) begin
         @(posedge i_clk_sys);
         #1;
         hit  = emulate_flag_mode ? (p0_oe === 8'hff) : (valid === 1'b1);
         data = emulate_flag_mode ? p0_out : cpu_rdata;
      end
      cyc(addr[7:0], addr[15:8], 1'b0, 2'b11);
      repeat (4) @(posedge i_clk_sys);
   endtask

   task finish_test;
      $display("total_checks %0d bad_count %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      bad_count = bad_count + 1;
      finish_test;
   end

   initial begin
      bases[0] = 8'h80;
      bases[1] = 8'h01;
      bases[2] = 8'hff;
      repeat (5) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus_read(16'hffff, d, ok);
      check8(d, `PAGE_BASE_RESET);
      check1(hold, 1'b0);
      for (i = 0; i < 3; i = i + 1) begin
         bus_write(`PAGE_BASE_ADDR, bases[i]);
         check8(p2_oe, 8'hff);
         n = rd_count;
         bus_read(16'hffff, d, ok);
         check8(d, bases[i]);
         check8(rd_count, n);
         bus_write({bases[i], 8'h06}, 8'h30 + i[7:0]);
         bus_read({bases[i], 8'h06}, d, ok);
         check8(d, 8'h30 + i[7:0]);
         bus_read({bases[i] ^ 8'h40, 8'h06}, d, ok);
         check1(ok, 1'b0);
      end
      for (i = 0; i < 4; i = i + 1) begin
         @(posedge i_clk_sys);
         route   <= i[1:0];
         net_irq <= 1'b1;
         repeat (3) @(posedge i_clk_sys);
         #1;
         check1(irq_a, i == 1);
         check1(irq_b, i == 2);
         if (i == 3) check1(p1_out[5], 1'b0);
      end
      // port 1 bit 2 idles high from the processor, so only the route pulls it low
      @(posedge i_clk_sys);
      irq_pin <= 3'h2;
      repeat (2) @(posedge i_clk_sys);
      #1;
      check1(p1_out[2], 1'b0);
      @(posedge i_clk_sys);
      route     <= `ROUTE_NONE;
      net_irq   <= 1'b0;
      pin_irq_n <= 2'b10;
      repeat (5) @(posedge i_clk_sys);
      #1;
      check1(irq_a, 1'b1);
      check1(irq_b, 1'b0);
      @(posedge i_clk_sys);
      pin_irq_n <= 2'b11;
      psen_n    <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      #1;
      check1(psen_out, 1'b0);
      check8(p2_out, 8'hbf);
      net_n = 0;
      cpu_n = 0;
      repeat (40) begin
         @(posedge i_clk_sys);
         #1;
         net_n = net_n + net_en;
         cpu_n = cpu_n + cpu_en;
      end
      check8(net_n[7:0], `NET_CLK_MHZ);
      check8(cpu_n[7:0], `CPU_CLK_MHZ);
      // page sits at ff00 now, clear of any external memory
      @(posedge i_clk_sys);
      ea_n      <= 1'b1;
      psen_n    <= 1'b1;
      emulate_flag_mode = 1'b1;
      repeat (7) @(posedge i_clk_sys);
      #1;
      check1(hold, 1'b1);
      check8(p3_oe, 8'h0c);
      check8(p1_oe, 8'h00);
      bus_read(16'hff06, d, ok);
      check8(d, 8'h32);
      @(posedge i_clk_sys);
      route   <= `ROUTE_INT_A;
      net_irq <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      #1;
      check1(p3_out[2], 1'b0);
      @(posedge i_clk_sys);
      i_rst     <= 1'b1;
      ea_n      <= 1'b0;
      net_irq   <= 1'b0;
      emulate_flag_mode = 1'b0;
      repeat (2) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      bus_read(16'hffff, d, ok);
      check8(d, `PAGE_BASE_RESET);
      finish_test;
   end
endmodule // core_page_decoder_emulate_mux_bench

// [core_page_decoder_emulate_mux_properties.sv]
/*
 * Concurrent checks for the core page decoder and emulate mux.
 * Assumes it is bound to the design top and sees only its ports.
 */
`timescale 1ns/1ns
`include "core_page_defines.vh"

module core_page_checker #(
   parameter DIV_W = 8
) (
   input wire       i_clk_sys,
   input wire       i_rst,
   input wire       i_external_access_select_n,
   input wire [7:0] i_p3_in,
   input wire [7:0] o_p1_oe,
   input wire [7:0] o_p2_oe,
   input wire [7:0] o_p3_oe,
   input wire       o_ale_oe,
   input wire       o_program_fetch_strobe_n_oe,
   input wire       o_cpu_hold,
   input wire [7:0] o_cpu_rdata,
   input wire       o_cpu_rdata_valid,
   input wire       o_cpu_ext_irq_a,
   input wire       o_cpu_ext_irq_b,
   input wire       o_core_rd,
   input wire       o_core_wr,
   input wire [7:0] i_core_rdata,
   input wire       i_net_irq,
   input wire [1:0] i_irq_route,
   input wire       o_net_clk_en,
   input wire       o_cpu_clk_en
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   // two cycles of hold so pin turnaround has landed
   sequence s_emulate_flag_steady;
      o_cpu_hold [*2];
   endsequence
   sequence s_core_read;
      o_core_rd ##1 o_cpu_rdata_valid;
   endsequence

   hold_on_emulate_flag_a: assert property (i_external_access_select_n [*5] |-> o_cpu_hold)
      else $error("hold missing in emulate");
   hold_off_normal_a: assert property (!i_external_access_select_n [*5] |-> !o_cpu_hold)
      else $error("hold set in normal mode");
   emulate_flag_bus_in_a: assert property (s_emulate_flag_steady |->
      o_p2_oe == 8'h00 && !o_ale_oe && !o_program_fetch_strobe_n_oe)
      else $error("bus pins driven in emulate");
   emulate_flag_p3_dir_a: assert property (s_emulate_flag_steady |-> o_p3_oe == 8'h0c)
      else $error("port 3 direction wrong in emulate");
   emulate_flag_p1_float_a: assert property (s_emulate_flag_steady ##0 (i_irq_route != `ROUTE_PORT) [*2]
      |-> o_p1_oe == 8'h00)
      else $error("port 1 driven in emulate");
   normal_irq_in_a: assert property (!o_cpu_hold [*2] |-> o_p3_oe[3:2] == 2'b00)
      else $error("irq pins driven in normal mode");
   read_valid_a: assert property (o_core_rd |-> s_core_read)
      else $error("core read without valid data");
   read_data_a: assert property (o_core_rd |=> o_cpu_rdata == $past(i_core_rdata))
      else $error("core read data not passed on");
   core_pulse_a: assert property ((o_core_rd || o_core_wr) |=> !(o_core_rd || o_core_wr))
      else $error("core strobe longer than one cycle");
   route_a_a: assert property (i_irq_route == `ROUTE_INT_A && i_net_irq |=> o_cpu_ext_irq_a)
      else $error("net irq not on irq a");
   route_b_a: assert property (i_irq_route == `ROUTE_INT_B && i_net_irq |=> o_cpu_ext_irq_b)
      else $error("net irq not on irq b");
   irq_quiet_a: assert property ((i_irq_route == `ROUTE_NONE && i_p3_in[3:2] == 2'b11) [*5]
      |-> !o_cpu_ext_irq_a && !o_cpu_ext_irq_b)
      else $error("irq raised with no source");
   net_clk_half_a: assert property (o_net_clk_en ##1 !o_net_clk_en |=> o_net_clk_en)
      else $error("network enable not half rate");
   cpu_clk_gap_a: assert property (o_cpu_clk_en |=> !o_cpu_clk_en)
      else $error("processor enable back to back");
endmodule // core_page_checker

bind core_page_decoder_emulate_mux core_page_checker #(.DIV_W(DIV_W)) u_checker (
   .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_external_access_select_n(i_external_access_select_n),
   .i_p3_in(i_p3_in), .o_p1_oe(o_p1_oe), .o_p2_oe(o_p2_oe), .o_p3_oe(o_p3_oe),
   .o_ale_oe(o_ale_oe), .o_program_fetch_strobe_n_oe(o_program_fetch_strobe_n_oe),
   .o_cpu_hold(o_cpu_hold), .o_cpu_rdata(o_cpu_rdata), .o_cpu_rdata_valid(o_cpu_rdata_valid),
   .o_cpu_ext_irq_a(o_cpu_ext_irq_a), .o_cpu_ext_irq_b(o_cpu_ext_irq_b),
   .o_core_rd(o_core_rd), .o_core_wr(o_core_wr), .i_core_rdata(i_core_rdata),
   .i_net_irq(i_net_irq), .i_irq_route(i_irq_route), .o_net_clk_en(o_net_clk_en),
   .o_cpu_clk_en(o_cpu_clk_en));

// [core_page_defines.vh]
/*
 * Constants for the core page decoder and emulate mux: register address,
 * reset values, port 3 bit roles, decode results, interrupt routes and clocks.
 * Assumes inclusion by bare name from the design files; definitions only.
 */
`ifndef CORE_PAGE_DEFINES_VH
`define CORE_PAGE_DEFINES_VH

// ---------------------------------------------------------------
// page base register
// ---------------------------------------------------------------
`define PAGE_BASE_ADDR      16'hffff
`define PAGE_BASE_RESET     8'h00

// ---------------------------------------------------------------
// port 3 bit positions
// ---------------------------------------------------------------
`define P3_TX               1
`define P3_INT_A            2
`define P3_INT_B            3
`define P3_T0               4
`define P3_T1               5
`define P3_WR               6
`define P3_RD               7

// ---------------------------------------------------------------
// address decode results
// ---------------------------------------------------------------
`define HIT_NONE            2'h0
`define HIT_PAGE_REG        2'h1
`define HIT_CORE            2'h2

// ---------------------------------------------------------------
// network interrupt routes
// ---------------------------------------------------------------
`define ROUTE_NONE          2'h0
`define ROUTE_INT_A         2'h1
`define ROUTE_INT_B         2'h2
`define ROUTE_PORT          2'h3

// ---------------------------------------------------------------
// clock rates in MHz
// ---------------------------------------------------------------
`define OSC_MHZ             40
`define NET_CLK_MHZ         20
`define CPU_CLK_MHZ         16

`endif

// [net_core_model.sv]
/*
 * Behavioural network core register file standing behind the page decoder.
 * Assumes reads are answered combinationally while the read pulse is high.
 */
`timescale 1ns/1ns

module net_core_model (
   input  wire       i_clk_sys,
   input  wire       i_rst,
   input  wire       i_rd,
   input  wire       i_wr,
   input  wire [7:0] i_addr,
   input  wire [7:0] i_wdata,
   output wire [7:0] o_rdata
);
   reg     [7:0] regs [0:255];
   integer       k;

   // outside a read the bus shows junk, so a stale sample cannot pass
   assign o_rdata = i_rd ? regs[i_addr] : ~regs[i_addr];

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         for (k = 0; k < 256; k = k + 1) begin
            regs[k] <= k[7:0] ^ 8'h5a;
         end
      end else if (i_wr) begin
         regs[i_addr] <= i_wdata;
      end
   end
endmodule // net_core_model

// [rate_enable_gen.v]
/*
 * Fractional clock enable: pulses on average RATE_NUM times for every
 * RATE_DEN clock cycles, by a phase accumulator.
 * Assumes RATE_NUM <= RATE_DEN and both fit in ACC_W bits.
 */
`timescale 1ns/1ns

module rate_enable_gen #(
   parameter ACC_W    = 8,
   parameter RATE_NUM = 1,
   parameter RATE_DEN = 2
) (
   input  wire             i_clk_sys,
   input  wire             i_rst,
   output reg              o_en
);

   localparam [ACC_W-1:0] STEP = RATE_NUM[ACC_W-1:0];
   localparam [ACC_W-1:0] WRAP = RATE_DEN[ACC_W-1:0];

   reg  [ACC_W-1:0] acc;
   wire [ACC_W:0]   sum;

   // one extra bit so the sum never wraps before the compare
   assign sum = {1'b0, acc} + {1'b0, STEP};

   always @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         acc  <= {ACC_W{1'b0}};
         o_en <= 1'b0;
      end else if (sum >= {1'b0, WRAP}) begin
         acc  <= sum[ACC_W-1:0] - WRAP;
         o_en <= 1'b1;
      end else begin
         acc  <= sum[ACC_W-1:0];
         o_en <= 1'b0;
      end
   end

endmodule // rate_enable_gen
